// [include/cmct_pkg.sv]
// Constants, types and address map of the carrier shelf control and timing block.
package cmct_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int FP_WIDTH_NS = 97;
  localparam int FP_CYC_I = (FP_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] FP_CYC = 2'((FP_CYC_I < 1) ? 1 : FP_CYC_I);
  localparam int BLANK_MS = 100;
  localparam logic [19:0] BLANK_CYC = 20'(BLANK_MS * 1000000 / CLK_PERIOD_NS);

  localparam logic [2:0] FE_LIMIT = 3'h4;
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [3:0] MSG_BITS = 4'h8;
  localparam logic [4:0] CH_MSG = 5'h00;
  localparam logic [4:0] CH_TX_LOAD = 5'h04;
  localparam logic [4:0] CH_RST = 5'h1f;
  localparam logic [4:0] CH_AT_FP = 5'h1f;
  localparam logic [4:0] CH_FRAME_END = 5'h1e;
  localparam logic [3:0] RST_BIT_A = 4'h2;
  localparam logic [3:0] RST_BIT_B = 4'h6;

  localparam int PER_W = 8;
  localparam int PLL_HALF_SHIFT = 1;
  localparam int SHELF_DIV_SHIFT = 3;

  localparam int RAM_BYTES = 2048;
  localparam int RAM_AW = 11;
  localparam int TX_AREA_BIT = 10;
  localparam logic [11:0] A_RAM_END = 12'h800;

  localparam logic [11:0] A_RX0 = 12'h800;
  localparam logic [11:0] A_RX1 = 12'h801;
  localparam logic [11:0] A_TX0 = 12'h802;
  localparam logic [11:0] A_TX1 = 12'h803;
  localparam logic [11:0] A_DOORBELL = 12'h804;
  localparam logic [11:0] A_CTL = 12'h805;
  localparam logic [11:0] A_STATUS = 12'h806;
  localparam logic [11:0] A_SLIP_CH = 12'h807;
  localparam logic [11:0] A_SLIP_BIT = 12'h808;
  localparam logic [11:0] A_MAINT_TX = 12'h809;

  localparam logic [11:0] P_MAINT = 12'h800;
  localparam logic [11:0] P_IRQ_CLR = 12'h801;
  localparam logic [11:0] P_SLIP_CH = 12'h802;
  localparam logic [11:0] P_SLIP_BIT = 12'h803;

  localparam int CTL_CPU_RST_BIT = 0;
  localparam int CTL_SHELF_RST_BIT = 1;
  localparam int DOORBELL_BIT = 0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [2:0] {
    CMCT_ST_IDLE = 3'b001,
    CMCT_ST_HOLD = 3'b010,
    CMCT_ST_ACC = 3'b100
  } cmct_hold_e;

endpackage

// [include/cmct_sw_if.sv]
// Signals between the timing core and the plane switch controller.
`timescale 1ns/1ps
interface cmct_sw_if;
  logic [1:0] fe;
  logic sel;
  logic sw;
  logic blank;
  modport ctl (input fe, output sel, output sw, output blank);
  modport core (output fe, input sel, input sw, input blank);
endinterface

// [rtl/cmct_clk_switch.sv]
// Plane switch controller: counts framing errors and picks the plane.
`timescale 1ns/1ps
module cmct_clk_switch #(
  parameter logic [19:0] BLANK_CYC = cmct_pkg::BLANK_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Link to the timing core.
  cmct_sw_if.ctl sw
);

  logic [2:0] fe_cnt_q;
  logic sel_q;
  logic sw_q;
  logic [19:0] blank_q;
  logic fe_sel;
  logic sw_d;

  assign fe_sel = sw.fe[sel_q] && (blank_q == 20'h00000);
  assign sw_d = fe_sel && (fe_cnt_q == 3'(cmct_pkg::FE_LIMIT - 3'h1));

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      fe_cnt_q <= 3'h0;
    else if (sw_d)
      fe_cnt_q <= 3'h0;
    else if (fe_sel)
      fe_cnt_q <= 3'(fe_cnt_q + 3'h1);
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_q <= 1'b0;
      sw_q <= 1'b0;
    end
    else
    begin
      sel_q <= sel_q ^ sw_d;
      sw_q <= sw_d;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      blank_q <= 20'h00000;
    else if (sw_d)
      blank_q <= BLANK_CYC;
    else if (blank_q != 20'h00000)
      blank_q <= 20'(blank_q - 20'h00001);
  end

  assign sw.sel = sel_q;
  assign sw.sw = sw_q;
  assign sw.blank = (blank_q != 20'h00000);

endmodule

// [rtl/cmct_top.sv]
// Carrier shelf control and timing: plane select, timing, messages, RAM and maintenance.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module cmct_top #(
  parameter logic [19:0] BLANK_CYC = cmct_pkg::BLANK_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Network port 0 planes.
  input wire logic [1:0] net_clk_i,
  input wire logic [1:0] net_fp_i,
  input wire logic [1:0] net_rx_i,
  output logic [1:0] net_tx_q,
  // Shelf timing and resets.
  output logic pll_clk_q,
  output logic shelf_clk_q,
  output logic shelf_fp_q,
  output logic shelf_rst_q,
  output logic cpu_rst_q,
  output logic cpu_hold_q,
  // Maintenance and slip inputs, and the maintenance output byte.
  input wire logic [3:0] scan_i,
  input wire logic t1_fp_i,
  output logic [7:0] maint_tx_q,
  // Control processor register port.
  input wire logic [11:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata_q,
  // Peripheral processor bus.
  input wire logic [11:0] pp_addr,
  input wire logic [7:0] pp_data_in,
  output logic [7:0] pp_data_out_q,
  output logic pp_data_oe_q,
  input wire logic pp_rd_i,
  input wire logic pp_wr_i,
  output logic pp_irq_q
);

  localparam int SYW = 33;

  function automatic logic is_ram(input logic [11:0] a);
    return a < cmct_pkg::A_RAM_END;
  endfunction

  // Every network, scan, T1 and peripheral bus pin passes two flip-flops before use.
  logic [SYW-1:0] async_w;
  logic [SYW-1:0] meta_q;
  logic [SYW-1:0] sync_q;
  assign async_w = {pp_data_in, pp_addr, pp_wr_i, pp_rd_i, t1_fp_i, scan_i,
                    net_rx_i, net_fp_i, net_clk_i};

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_w;
      sync_q <= meta_q;
    end
  end

  logic [1:0] s_clk;
  logic [1:0] s_fp;
  logic [1:0] s_rx;
  logic [3:0] s_scan;
  logic s_t1;
  logic s_rd;
  logic s_wr;
  logic [11:0] s_addr;
  logic [7:0] s_din;
  assign s_clk = sync_q[1:0];
  assign s_fp = sync_q[3:2];
  assign s_rx = sync_q[5:4];
  assign s_scan = sync_q[9:6];
  assign s_t1 = sync_q[10];
  assign s_rd = sync_q[11];
  assign s_wr = sync_q[12];
  assign s_addr = sync_q[24:13];
  assign s_din = sync_q[32:25];

  cmct_sw_if swi ();

  cmct_clk_switch #(
    .BLANK_CYC(BLANK_CYC)
  ) u_switch (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sw(swi)
  );

  logic sel;
  assign sel = swi.sel;

  // Edge detection on the selected plane and other slow inputs.
  logic clk_d_q;
  logic [1:0] fp_d_q;
  logic t1_d_q;
  logic acc_d_q;
  logic rise;
  logic [1:0] fp_rise;
  logic frame_start;
  logic t1_rise;
  logic pp_req;

  assign rise = s_clk[sel] & ~clk_d_q;
  assign fp_rise = s_fp & ~fp_d_q;
  assign frame_start = fp_rise[sel];
  assign t1_rise = s_t1 & ~t1_d_q;
  assign pp_req = (s_rd | s_wr) & ~acc_d_q;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clk_d_q <= 1'b0;
      fp_d_q <= 2'h0;
      t1_d_q <= 1'b0;
      acc_d_q <= 1'b0;
    end
    else
    begin
      clk_d_q <= s_clk[sel];
      fp_d_q <= s_fp;
      t1_d_q <= s_t1;
      acc_d_q <= s_rd | s_wr;
    end
  end

  // Bit and channel counters.
  logic [3:0] bit_q;
  logic [4:0] chan_q;
  logic at_end;
  logic miss;
  logic in_ch0;
  logic in_msg;
  assign at_end = (bit_q == cmct_pkg::BIT_LAST) && (chan_q == cmct_pkg::CH_FRAME_END);
  assign miss = rise && at_end && !frame_start;
  assign in_ch0 = (chan_q == cmct_pkg::CH_MSG);
  assign in_msg = in_ch0 && (bit_q < cmct_pkg::MSG_BITS);
  assign swi.fe = (fp_rise & {2{~at_end}}) | ({sel, ~sel} & {2{miss}});

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_q <= 4'h0;
      chan_q <= cmct_pkg::CH_AT_FP;
    end
    else if (frame_start)
    begin
      bit_q <= 4'h0;
      chan_q <= cmct_pkg::CH_AT_FP;
    end
    else if (rise)
    begin
      if (bit_q == cmct_pkg::BIT_LAST)
      begin
        bit_q <= 4'h0;
        chan_q <= 5'(chan_q + 5'h01);
      end
      else
        bit_q <= 4'(bit_q + 4'h1);
    end
  end

  // Regenerated line clock and derived shelf clock.
  logic [cmct_pkg::PER_W-1:0] per_cnt_q;
  logic [cmct_pkg::PER_W-1:0] per_q;
  logic [cmct_pkg::PER_W-1:0] sc_cnt_q;
  logic [cmct_pkg::PER_W-1:0] eighth;
  assign eighth = ((per_q >> cmct_pkg::SHELF_DIV_SHIFT) == '0) ? 8'h01
                  : (per_q >> cmct_pkg::SHELF_DIV_SHIFT);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      per_cnt_q <= 8'h01;
      per_q <= 8'h00;
      pll_clk_q <= 1'b0;
    end
    else if (rise)
    begin
      per_q <= per_cnt_q;
      per_cnt_q <= 8'h01;
      // The clock stays low until one whole period has been measured.
      pll_clk_q <= (per_q != 8'h00);
    end
    else
    begin
      if (per_cnt_q != 8'hff)
        per_cnt_q <= 8'(per_cnt_q + 8'h01);
      if (per_cnt_q == (per_q >> cmct_pkg::PLL_HALF_SHIFT))
        pll_clk_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sc_cnt_q <= 8'h01;
      shelf_clk_q <= 1'b0;
    end
    else if (rise)
    begin
      sc_cnt_q <= 8'h01;
      shelf_clk_q <= 1'b1;
    end
    else if (sc_cnt_q >= eighth)
    begin
      sc_cnt_q <= 8'h01;
      shelf_clk_q <= ~shelf_clk_q;
    end
    else
      sc_cnt_q <= 8'(sc_cnt_q + 8'h01);
  end

  logic [1:0] fp_cnt_q;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fp_cnt_q <= 2'h0;
      shelf_fp_q <= 1'b0;
    end
    else if (frame_start)
    begin
      fp_cnt_q <= cmct_pkg::FP_CYC;
      shelf_fp_q <= 1'b1;
    end
    else
    begin
      if (fp_cnt_q != 2'h0)
        fp_cnt_q <= 2'(fp_cnt_q - 2'h1);
      shelf_fp_q <= (fp_cnt_q > 2'h1);
    end
  end

  // Timeslot zero message shifters, one set per plane.
  logic [7:0] tx_msg_q [2];
  logic [7:0] rx_msg_w [2];

  for (genvar p = 0; p < 2; p++)
  begin : g_plane
    logic [7:0] rx_sh_q;
    logic [7:0] rx_msg_q;
    logic [7:0] tx_sh_q;
    logic tx_bit_q;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
      if (!arst_n)
      begin
        rx_sh_q <= cmct_pkg::BYTE_RESET;
        rx_msg_q <= cmct_pkg::BYTE_RESET;
      end
      else if (rise && in_msg)
        rx_sh_q <= {rx_sh_q[6:0], s_rx[p]};
      else if (rise && in_ch0 && bit_q == cmct_pkg::BIT_LAST)
        rx_msg_q <= rx_sh_q;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
      if (!arst_n)
      begin
        tx_sh_q <= cmct_pkg::BYTE_RESET;
        tx_bit_q <= 1'b0;
      end
      else if (rise)
      begin
        tx_bit_q <= in_msg ? tx_sh_q[7] : 1'b0;
        if (chan_q == cmct_pkg::CH_TX_LOAD && bit_q == cmct_pkg::BIT_LAST)
          tx_sh_q <= tx_msg_q[p];
        else if (in_msg)
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end

    assign rx_msg_w[p] = rx_msg_q;
    assign net_tx_q[p] = tx_bit_q;
  end

  // Peripheral access arbitration with hold.
  cmct_pkg::cmct_hold_e st_q;
  cmct_pkg::cmct_hold_e st_d;
  logic acc;
  always_comb
  begin
    case (st_q)
      cmct_pkg::CMCT_ST_IDLE: st_d = pp_req ? cmct_pkg::CMCT_ST_HOLD : cmct_pkg::CMCT_ST_IDLE;
      cmct_pkg::CMCT_ST_HOLD: st_d = cmct_pkg::CMCT_ST_ACC;
      cmct_pkg::CMCT_ST_ACC: st_d = cmct_pkg::CMCT_ST_IDLE;
      default: st_d = cmct_pkg::CMCT_ST_IDLE;
    endcase
  end
  assign acc = (st_q == cmct_pkg::CMCT_ST_ACC);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= cmct_pkg::CMCT_ST_IDLE;
      cpu_hold_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cpu_hold_q <= (st_d != cmct_pkg::CMCT_ST_IDLE);
    end
  end

  // Shared message RAM.
  logic [7:0] ram_q [cmct_pkg::RAM_BYTES];
  logic pp_we;
  logic cpu_we;
  assign pp_we = acc && s_wr && is_ram(s_addr) && s_addr[cmct_pkg::TX_AREA_BIT];
  assign cpu_we = cpu_wr && is_ram(cpu_addr) && !pp_we;

  always_ff @(posedge clk_sys)
  begin
    if (pp_we)
      ram_q[s_addr[cmct_pkg::RAM_AW-1:0]] <= s_din;
    else if (cpu_we)
      ram_q[cpu_addr[cmct_pkg::RAM_AW-1:0]] <= cpu_wdata;
  end

  // Doorbell, maintenance, slip and control state.
  logic [1:0] fe_seen_q;
  logic [3:0] slip_bit_q;
  logic [4:0] slip_ch_q;
  logic cpu_rst_req_q;
  logic [7:0] maint_rx;
  assign maint_rx = {1'b0, sel, fe_seen_q, s_scan};

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pp_irq_q <= 1'b0;
    else if (cpu_wr && cpu_addr == cmct_pkg::A_DOORBELL && cpu_wdata[cmct_pkg::DOORBELL_BIT])
      pp_irq_q <= 1'b1;
    else if (acc && s_rd && s_addr == cmct_pkg::P_IRQ_CLR)
      pp_irq_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      fe_seen_q <= 2'h0;
    else
      fe_seen_q <= swi.fe | (fe_seen_q & {2{~(acc && s_rd && s_addr == cmct_pkg::P_MAINT)}});
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slip_ch_q <= 5'h00;
      slip_bit_q <= 4'h0;
    end
    else if (t1_rise)
    begin
      slip_ch_q <= chan_q;
      slip_bit_q <= bit_q;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_msg_q[0] <= cmct_pkg::BYTE_RESET;
      tx_msg_q[1] <= cmct_pkg::BYTE_RESET;
      shelf_rst_q <= 1'b0;
    end
    else if (cpu_wr)
    begin
      if (cpu_addr == cmct_pkg::A_TX0)
        tx_msg_q[0] <= cpu_wdata;
      if (cpu_addr == cmct_pkg::A_TX1)
        tx_msg_q[1] <= cpu_wdata;
      if (cpu_addr == cmct_pkg::A_CTL)
        shelf_rst_q <= cpu_wdata[cmct_pkg::CTL_SHELF_RST_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      cpu_rst_req_q <= 1'b0;
    else if (cpu_wr && cpu_addr == cmct_pkg::A_CTL && cpu_wdata[cmct_pkg::CTL_CPU_RST_BIT])
      cpu_rst_req_q <= 1'b1;
    else if (rise && chan_q == cmct_pkg::CH_RST && bit_q == cmct_pkg::RST_BIT_B)
      cpu_rst_req_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      cpu_rst_q <= 1'b0;
    else
      cpu_rst_q <= cpu_rst_req_q && (chan_q == cmct_pkg::CH_RST)
                   && (bit_q == cmct_pkg::RST_BIT_A || bit_q == cmct_pkg::RST_BIT_B);
  end

  // Read decode for both processors.
  logic [7:0] cpu_rd_val;
  logic [7:0] pp_rd_val;
  always_comb
  begin
    cpu_rd_val = 8'h00;
    if (is_ram(cpu_addr))
      cpu_rd_val = ram_q[cpu_addr[cmct_pkg::RAM_AW-1:0]];
    else
      case (cpu_addr)
        cmct_pkg::A_RX0: cpu_rd_val = rx_msg_w[0];
        cmct_pkg::A_RX1: cpu_rd_val = rx_msg_w[1];
        cmct_pkg::A_TX0: cpu_rd_val = tx_msg_q[0];
        cmct_pkg::A_TX1: cpu_rd_val = tx_msg_q[1];
        cmct_pkg::A_DOORBELL: cpu_rd_val = {7'h00, pp_irq_q};
        cmct_pkg::A_CTL: cpu_rd_val = {6'h00, shelf_rst_q, cpu_rst_req_q};
        cmct_pkg::A_STATUS: cpu_rd_val = maint_rx;
        cmct_pkg::A_SLIP_CH: cpu_rd_val = {3'h0, slip_ch_q};
        cmct_pkg::A_SLIP_BIT: cpu_rd_val = {4'h0, slip_bit_q};
        cmct_pkg::A_MAINT_TX: cpu_rd_val = maint_tx_q;
        default: cpu_rd_val = 8'h00;
      endcase
  end

  always_comb
  begin
    pp_rd_val = 8'h00;
    if (is_ram(s_addr))
      pp_rd_val = ram_q[s_addr[cmct_pkg::RAM_AW-1:0]];
    else
      case (s_addr)
        cmct_pkg::P_MAINT: pp_rd_val = maint_rx;
        cmct_pkg::P_IRQ_CLR: pp_rd_val = {7'h00, pp_irq_q};
        cmct_pkg::P_SLIP_CH: pp_rd_val = {3'h0, slip_ch_q};
        cmct_pkg::P_SLIP_BIT: pp_rd_val = {4'h0, slip_bit_q};
        default: pp_rd_val = 8'h00;
      endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      cpu_rdata_q <= 8'h00;
    else
      cpu_rdata_q <= cpu_rd ? cpu_rd_val : 8'h00;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pp_data_out_q <= 8'h00;
      pp_data_oe_q <= 1'b0;
      maint_tx_q <= 8'h00;
    end
    else
    begin
      if (acc && s_rd)
      begin
        pp_data_out_q <= pp_rd_val;
        pp_data_oe_q <= 1'b1;
      end
      else if (!s_rd)
        pp_data_oe_q <= 1'b0;
      if (acc && s_wr && s_addr == cmct_pkg::P_MAINT)
        maint_tx_q <= s_din;
    end
  end

endmodule

// [verif/cmct_properties.sv]
// Port checker of the carrier shelf control and timing block.
`timescale 1ns/1ps
module cmct_properties #(
  parameter logic [19:0] BLANK_CYC = cmct_pkg::BLANK_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Shelf timing and resets.
  input wire logic pll_clk_q,
  input wire logic shelf_fp_q,
  input wire logic shelf_rst_q,
  input wire logic cpu_rst_q,
  input wire logic cpu_hold_q,
  input wire logic [7:0] maint_tx_q,
  // Control processor port.
  input wire logic [11:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  // Peripheral processor bus.
  input wire logic pp_rd_i,
  input wire logic pp_wr_i,
  input wire logic pp_data_oe_q,
  input wire logic pp_irq_q
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_hold_pair;
    cpu_hold_q ##1 !cpu_hold_q;
  endsequence
  sequence s_rst_slot;
    cpu_rst_q [*6] ##[1:3] !cpu_rst_q;
  endsequence

  a_hold_two_cycles: assert property ($rose(cpu_hold_q) |=> s_hold_pair)
    else $error("hold not two cycles long");
  a_hold_has_cause: assert property ($rose(cpu_hold_q) |-> (pp_rd_i || pp_wr_i))
    else $error("hold without peripheral strobe");
  a_fp_single_cycle: assert property ($rose(shelf_fp_q) |=> !shelf_fp_q)
    else $error("shelf frame pulse too wide");
  a_pll_half_period: assert property ($rose(pll_clk_q) |=> pll_clk_q [*3])
    else $error("line clock high phase too short");
  a_irq_on_write: assert property (cpu_wr && cpu_addr == cmct_pkg::A_DOORBELL && cpu_wdata[0]
    |-> ##[1:2] pp_irq_q)
    else $error("doorbell write raised no interrupt");
  a_irq_clear_read: assert property ($fell(pp_irq_q) |-> pp_rd_i)
    else $error("interrupt cleared without peripheral read");
  a_shelf_rst_set: assert property (cpu_wr && cpu_addr == cmct_pkg::A_CTL && cpu_wdata[1]
    |-> ##[1:2] shelf_rst_q)
    else $error("shelf reset not driven");
  a_cpu_rst_slot: assert property ($rose(cpu_rst_q) |=> s_rst_slot)
    else $error("processor reset not one bit slot wide");
  a_maint_in_hold: assert property ($changed(maint_tx_q) |-> $past(cpu_hold_q))
    else $error("maintenance byte changed outside hold");
  a_oe_after_hold: assert property ($rose(pp_data_oe_q) |-> pp_rd_i && $past(cpu_hold_q))
    else $error("data driven without held read");
endmodule

// [verif/cmct_net_planes.sv]
// Model of the two network port planes: link clock, frame pulse and message timeslot.
`timescale 1ns/1ps
module cmct_net_planes #(
  parameter logic [7:0] RX0 = 8'h5a,
  parameter logic [7:0] RX1 = 8'hc3
) (
  // Bench control.
  input wire logic [1:0] drop_fp,
  // Plane pins.
  output logic [1:0] net_clk,
  output logic [1:0] net_fp,
  output logic [1:0] net_rx,
  input wire logic [1:0] net_tx,
  // Bytes seen in the message timeslot.
  output logic [7:0] tx0_seen,
  output logic [7:0] tx1_seen
);
  logic lclk;
  int pos;
  int nxt;
  assign net_clk = {lclk, lclk};
  initial
  begin
    lclk = 1'h0;
    pos = 319;
    net_fp = 2'h0;
    net_rx = 2'h0;
    tx0_seen = 8'h00;
    tx1_seen = 8'h00;
    forever #400 lclk = ~lclk;
  end
  // Frame pulse rises with position 0; transmit bits are taken at the rise after their slot.
  always @(posedge lclk)
  begin
    pos <= (pos == 319) ? 0 : pos + 1;
    net_fp <= (pos == 319) ? ~drop_fp : 2'h0;
    if (pos >= 11 && pos <= 18)
    begin
      tx0_seen <= {tx0_seen[6:0], net_tx[0]};
      tx1_seen <= {tx1_seen[6:0], net_tx[1]};
    end
  end
  // Data changes half a bit before sampling; a toggling filler fills other slots.
  always @(negedge lclk)
  begin
    nxt = (pos == 319) ? 0 : pos + 1;
    net_rx[0] <= (nxt >= 11 && nxt <= 18) ? RX0[18-nxt] : ~net_rx[0];
    net_rx[1] <= (nxt >= 11 && nxt <= 18) ? RX1[18-nxt] : ~net_rx[1];
  end
endmodule

// [verif/tb_cmct_top.sv]
// Testbench of the carrier shelf control and timing block.
`timescale 1ns/1ps
module tb_cmct_top;
  logic clk_sys, arst_n, pll_clk_q, shelf_clk_q, shelf_fp_q, shelf_rst_q, cpu_rst_q;
  logic cpu_hold_q, t1_fp_i, cpu_wr, cpu_rd, pp_data_oe_q, pp_rd_i, pp_wr_i, pp_irq_q;
  logic [1:0] net_clk_i, net_fp_i, net_rx_i, net_tx_q, drop_fp;
  logic [3:0] scan_i;
  logic [11:0] cpu_addr, pp_addr;
  logic [7:0] maint_tx_q, cpu_wdata, cpu_rdata_q, pp_data_in, pp_data_out_q;
  logic [7:0] tx0_seen, tx1_seen, rd_val;
  int bad_count, cmp_count, n;

  cmct_top #(.BLANK_CYC(20'h000c8)) u_cmct_top (.clk_sys, .arst_n, .net_clk_i, .net_fp_i,
    .net_rx_i, .net_tx_q, .pll_clk_q, .shelf_clk_q, .shelf_fp_q, .shelf_rst_q, .cpu_rst_q,
    .cpu_hold_q, .scan_i, .t1_fp_i, .maint_tx_q, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd,
    .cpu_rdata_q, .pp_addr, .pp_data_in, .pp_data_out_q, .pp_data_oe_q, .pp_rd_i, .pp_wr_i,
    .pp_irq_q);
  cmct_net_planes u_cmct_net_planes (.drop_fp, .net_clk(net_clk_i), .net_fp(net_fp_i),
    .net_rx(net_rx_i), .net_tx(net_tx_q), .tx0_seen, .tx1_seen);

  initial
  begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    $display("Mismatches %0d in %0d comparisons", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_rng(input string what, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic cpu_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'h1;
    @(posedge clk_sys);
    cpu_wr <= 1'h0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_rd <= 1'h1;
    @(posedge clk_sys);
    cpu_rd <= 1'h0;
    @(negedge clk_sys);
    check(what, exp, cpu_rdata_q);
  endtask

  task automatic pp_access(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    pp_addr <= a;
    pp_data_in <= d;
    pp_wr_i <= wr;
    pp_rd_i <= !wr;
    for (n = 0; n < 20 && cpu_hold_q !== 1'h1; n++)
      @(negedge clk_sys);
    if (n == 20)
      bad_count++;
    repeat (3) @(negedge clk_sys);
    rd_val = pp_data_out_q;
    if (!wr)
      check("pp drive", 8'h01, {7'h00, pp_data_oe_q});
    @(posedge clk_sys);
    pp_wr_i <= 1'h0;
    pp_rd_i <= 1'h0;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic wait_frame();
    @(posedge clk_sys);
    for (n = 0; n < 3000 && shelf_fp_q !== 1'h1; n++)
      @(negedge clk_sys);
    if (n == 3000)
      bad_count++;
  endtask

  task automatic count_rise(ref logic s, input int cyc, output int k);
    logic last;
    last = s;
    k = 0;
    repeat (cyc)
    begin
      @(negedge clk_sys);
      if (s === 1'h1 && last !== 1'h1)
        k++;
      last = s;
    end
  endtask

  initial
  begin
    #8000000;
    bad_count++;
    wrap_up();
  end

  initial
  begin
    bad_count = 0;
    cmp_count = 0;
    arst_n = 1'h0;
    {cpu_wr, cpu_rd, pp_rd_i, pp_wr_i, t1_fp_i} = 5'h00;
    {cpu_addr, pp_addr, cpu_wdata, pp_data_in} = 40'h0;
    scan_i = 4'ha;
    drop_fp = 2'h0;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'h1;
    wait_frame();
    wait_frame();
    pp_access(1'h0, cmct_pkg::P_MAINT, 8'h00);
    cpu_write(12'h80a, 8'hff);
    rd_chk(12'h80a, 8'h00, "unmapped");
    cpu_write(12'h010, 8'h11);
    cpu_write(12'h410, 8'h22);
    pp_access(1'h1, 12'h010, 8'h33);
    pp_access(1'h1, 12'h410, 8'h44);
    rd_chk(12'h010, 8'h11, "ram receive area");
    rd_chk(12'h410, 8'h44, "ram transmit area");
    pp_access(1'h0, 12'h010, 8'h00);
    check("pp ram read", 8'h11, rd_val);
    cpu_write(cmct_pkg::A_DOORBELL, 8'h01);
    repeat (2) @(negedge clk_sys);
    check("irq set", 8'h01, {7'h00, pp_irq_q});
    rd_chk(cmct_pkg::A_DOORBELL, 8'h01, "doorbell");
    pp_access(1'h0, cmct_pkg::P_IRQ_CLR, 8'h00);
    check("irq clear", 8'h00, {7'h00, pp_irq_q});
    pp_access(1'h1, cmct_pkg::P_MAINT, 8'h5c);
    check("maint out", 8'h5c, maint_tx_q);
    rd_chk(cmct_pkg::A_MAINT_TX, 8'h5c, "maint readback");
    cpu_write(cmct_pkg::A_CTL, 8'h02);
    repeat (2) @(negedge clk_sys);
    check("shelf reset on", 8'h01, {7'h00, shelf_rst_q});
    cpu_write(cmct_pkg::A_CTL, 8'h00);
    repeat (2) @(negedge clk_sys);
    check("shelf reset off", 8'h00, {7'h00, shelf_rst_q});
    wait_frame();
    cpu_write(cmct_pkg::A_TX0, 8'ha5);
    cpu_write(cmct_pkg::A_TX1, 8'h3c);
    wait_frame();
    repeat (400) @(posedge clk_sys);
    check("tx plane0", 8'ha5, tx0_seen);
    check("tx plane1", 8'h3c, tx1_seen);
    rd_chk(cmct_pkg::A_RX0, 8'h5a, "rx plane0");
    rd_chk(cmct_pkg::A_RX1, 8'hc3, "rx plane1");
    rd_chk(cmct_pkg::A_STATUS, 8'h0a, "status");
    wait_frame();
    repeat (512) @(posedge clk_sys);
    t1_fp_i <= 1'h1;
    repeat (20) @(posedge clk_sys);
    t1_fp_i <= 1'h0;
    rd_chk(cmct_pkg::A_SLIP_CH, 8'h05, "slip channel");
    rd_chk(cmct_pkg::A_SLIP_BIT, 8'h04, "slip bit");
    cpu_write(cmct_pkg::A_CTL, 8'h01);
    wait_frame();
    count_rise(cpu_rst_q, 100, n);
    check_rng("cpu reset pulses", 2, 2, n);
    wait_frame();
    count_rise(cpu_rst_q, 100, n);
    check_rng("cpu reset again", 0, 0, n);
    rd_chk(cmct_pkg::A_CTL, 8'h00, "ctl cleared");
    count_rise(pll_clk_q, 800, n);
    check_rng("line clock rises", 99, 101, n);
    count_rise(shelf_clk_q, 800, n);
    check_rng("shelf clock rises", 398, 402, n);
    pp_access(1'h0, cmct_pkg::P_MAINT, 8'h00);
    drop_fp <= 2'h1;
    repeat (5200) @(posedge clk_sys);
    rd_chk(cmct_pkg::A_STATUS, 8'h1a, "two errors");
    repeat (5200) @(posedge clk_sys);
    rd_chk(cmct_pkg::A_STATUS, 8'h5a, "switched plane");
    drop_fp <= 2'h0;
    wrap_up();
  end
endmodule

bind cmct_top cmct_properties #(.BLANK_CYC(BLANK_CYC)) u_cmct_properties (.clk_sys, .arst_n,
  .pll_clk_q, .shelf_fp_q, .shelf_rst_q, .cpu_rst_q, .cpu_hold_q, .maint_tx_q, .cpu_addr,
  .cpu_wdata, .cpu_wr, .pp_rd_i, .pp_wr_i, .pp_data_oe_q, .pp_irq_q);
